// ==== inc/lrsd_cfg.svh ====
// Purpose: constants for the link request stream decoder
// Assumes: one bit per clock on the request line, msb first
// Notes: timing counts are in clock cycles
`ifndef LRSD_CFG_SVH
`define LRSD_CFG_SVH
`define LRSD_TYPE_IMM 3'h0
`define LRSD_TYPE_ISO 3'h1
`define LRSD_TYPE_PRI 3'h2
`define LRSD_TYPE_FAIR 3'h3
`define LRSD_TYPE_REGISTER_READ_REQUEST 3'h4
`define LRSD_TYPE_REGISTER_WRITE_REQUEST 3'h5
`define LRSD_TYPE_ACCEL 3'h6
`define LRSD_TYPE_RSVD 3'h7
`define LRSD_SPEED_S100 3'h0
`define LRSD_SPEED_S200 3'h2
`define LRSD_SPEED_S400 3'h4
`define LRSD_BUS_LEN 5'h08
`define LRSD_BUS_SHORT_LEN 5'h07
`define LRSD_RD_LEN 5'h09
`define LRSD_WR_LEN 5'h11
`define LRSD_ACC_LEN 5'h06
`define LRSD_TYPE_LAST 5'h03
`define LRSD_CTL_IDLE 2'h0
`define LRSD_CTL_STATUS 2'h1
`define LRSD_CTL_RECEIVE 2'h2
`define LRSD_CTL_GRANT 2'h3
`endif

// ==== inc/lrsd_pkg.sv ====
// Purpose: types for the link request stream decoder
// Assumes: nothing
// Notes: none
package lrsd_pkg;
  typedef enum logic [1:0] {
    LRSD_ST_IDLE,
    LRSD_ST_SHIFT,
    LRSD_ST_DRAIN
  } lrsd_state_t;
  typedef enum logic [1:0] {
    LRSD_ARB_NONE,
    LRSD_ARB_IMMEDIATE,
    LRSD_ARB_ON_IDLE,
    LRSD_ARB_AFTER_GAP
  } lrsd_arb_t;
endpackage

// ==== design/lrsd_bus_request_tracker.sv ====
// Purpose: holds the single outstanding bus request
// Assumes: load pulses come from the stream decoder
// Notes: receive state drops fair and priority requests only
`timescale 1ns/100ps
`default_nettype none
`include "lrsd_cfg.svh"
module lrsd_bus_request_tracker
  import lrsd_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic load,
  input wire logic [2:0] load_type,
  input wire logic [2:0] load_speed,
  input wire logic receive_state,
  input wire logic bus_won,
  input wire logic bus_reset,
  output logic pending,
  output logic [2:0] req_type,
  output logic [2:0] req_speed
);
  wire is_fair_pri = (req_type == `LRSD_TYPE_PRI) || (req_type == `LRSD_TYPE_FAIR);
  wire drop_rx = pending && receive_state && is_fair_pri;
  wire take = load && !pending;

  always_ff @(posedge clk) begin
    if (srst) begin
      pending <= 1'b0;
      req_type <= 3'h0;
      req_speed <= 3'h0;
    end else if (ce) begin
      if (bus_reset || bus_won || drop_rx) begin
        pending <= 1'b0;
      end else if (take) begin
        pending <= 1'b1;
        req_type <= load_type;
        req_speed <= load_speed;
      end
    end
  end
endmodule
`default_nettype wire

// ==== design/lrsd_register_read_tracker.sv ====
// Purpose: holds the pending register read until delivered
// Assumes: status path pulses delivered once all 8 bits went out
// Notes: bus reset leaves the pending read in place
`timescale 1ns/100ps
`default_nettype none
`include "lrsd_cfg.svh"
module lrsd_register_read_tracker
  import lrsd_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic load,
  input wire logic [3:0] load_addr,
  input wire logic delivered,
  output logic pending,
  output logic [3:0] addr
);
  always_ff @(posedge clk) begin
    if (srst) begin
      pending <= 1'b0;
      addr <= 4'h0;
    end else if (ce) begin
      if (load && !pending) begin
        pending <= 1'b1;
        addr <= load_addr;
      end else if (delivered) begin
        pending <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== design/lrsd_link_request_stream_decoder.sv ====
// Purpose: decodes the serial request stream from the link controller
// Assumes: request line synchronous to clk, sampled on rising edge
// Notes: register contents and status transfer live elsewhere
`timescale 1ns/100ps
`default_nettype none
`include "lrsd_cfg.svh"
module lrsd_link_request_stream_decoder
  import lrsd_pkg::*;
#(
  parameter int SHIFT_W = 17
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic link_request_line,
  input wire logic [1:0] interface_control_bus,
  input wire logic bus_won,
  input wire logic bus_reset,
  input wire logic read_delivered,
  input wire logic accel_enable_bit,
  output logic bus_req_pending,
  output logic [2:0] bus_req_type,
  output logic [2:0] bus_req_speed,
  output logic bus_req_speed_invalid,
  output logic [1:0] bus_req_arb_mode,
  output logic bus_req_fair,
  output logic read_pending,
  output logic [3:0] read_addr,
  output logic write_strobe,
  output logic [3:0] write_addr,
  output logic [7:0] write_data,
  output logic accel_enabled,
  output logic stream_error
);
  lrsd_state_t state;
  lrsd_state_t next_state;
  logic [SHIFT_W-1:0] shreg;
  logic [4:0] count;
  logic rx_seen;
  logic [2:0] rtype;

  function automatic logic [4:0] stream_len(input logic [2:0] t);
    case (t)
      `LRSD_TYPE_REGISTER_READ_REQUEST: stream_len = `LRSD_RD_LEN;
      `LRSD_TYPE_REGISTER_WRITE_REQUEST: stream_len = `LRSD_WR_LEN;
      `LRSD_TYPE_ACCEL: stream_len = `LRSD_ACC_LEN;
      // short form has idle low where the stop bit would be
      default: stream_len = `LRSD_BUS_LEN;
    endcase
  endfunction

  function automatic logic speed_ok(input logic [2:0] s);
    speed_ok = (s == `LRSD_SPEED_S100) || (s == `LRSD_SPEED_S200) ||
      (s == `LRSD_SPEED_S400);
  endfunction

  // bits after the start bit, newest in lsb; stream bit k sits at count-k
  wire [SHIFT_W-1:0] cur = {shreg[SHIFT_W-2:0], link_request_line};
  wire [4:0] got = count + 5'h01;
  // stream length up to and including the bit now on the line
  wire [4:0] seen = count + 5'h02;
  wire in_stream = (state == LRSD_ST_SHIFT);
  wire type_done = in_stream && (count == `LRSD_TYPE_LAST);
  // type sits in the low bits only while bit 4 is sampled, then is held
  wire [2:0] typ = (count == `LRSD_TYPE_LAST) ? shreg[2:0] : rtype;
  wire is_bus = !typ[2];
  // bus request always ends on sample 7: stop bit or idle low
  wire at_end = in_stream && (count > `LRSD_TYPE_LAST) && (typ != `LRSD_TYPE_RSVD) &&
    (seen == stream_len(typ));
  wire stop_ok = !link_request_line;
  wire rsvd_seen = type_done && (typ == `LRSD_TYPE_RSVD);
  wire receive_now = (interface_control_bus == `LRSD_CTL_RECEIVE);
  wire fair_pri = (typ == `LRSD_TYPE_PRI) || (typ == `LRSD_TYPE_FAIR);
  wire bus_load = at_end && stop_ok && is_bus &&
    !(fair_pri && (rx_seen || receive_now));
  wire [2:0] bus_spd = shreg[2:0];
  wire rx_window = (in_stream && !at_end) || ((state == LRSD_ST_IDLE) && link_request_line);
  wire rd_load = at_end && stop_ok && (typ == `LRSD_TYPE_REGISTER_READ_REQUEST);
  wire wr_hit = at_end && stop_ok && (typ == `LRSD_TYPE_REGISTER_WRITE_REQUEST);
  wire acc_hit = at_end && stop_ok && (typ == `LRSD_TYPE_ACCEL);
  wire bad_stop = at_end && !stop_ok;
  wire tr_pending;
  wire [2:0] tr_type;
  wire [2:0] tr_speed;
  wire rt_pending;
  wire [3:0] rt_addr;
  wire [1:0] arb_mode_now = (tr_type == `LRSD_TYPE_IMM) ? LRSD_ARB_IMMEDIATE :
    (tr_type == `LRSD_TYPE_ISO) ? LRSD_ARB_ON_IDLE : LRSD_ARB_AFTER_GAP;

  always_comb begin
    next_state = state;
    case (state)
      LRSD_ST_IDLE: begin
        if (link_request_line) begin
          next_state = LRSD_ST_SHIFT;
        end
      end
      LRSD_ST_SHIFT: begin
        if (rsvd_seen) begin
          next_state = LRSD_ST_DRAIN;
        end else if (at_end) begin
          next_state = stop_ok ? LRSD_ST_IDLE : LRSD_ST_DRAIN;
        end
      end
      LRSD_ST_DRAIN: begin
        if (!link_request_line) begin
          next_state = LRSD_ST_IDLE;
        end
      end
      default: next_state = LRSD_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= LRSD_ST_IDLE;
      shreg <= '0;
      count <= 5'h00;
      rx_seen <= 1'b0;
      rtype <= 3'h0;
    end else if (ce) begin
      rtype <= typ;
      state <= next_state;
      shreg <= (state == LRSD_ST_SHIFT) ? cur : '0;
      count <= (state == LRSD_ST_SHIFT) ? got : 5'h00;
      rx_seen <= rx_window && (rx_seen || receive_now);
    end
  end

  lrsd_bus_request_tracker u_bus (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .load(bus_load),
    .load_type(typ),
    .load_speed(bus_spd),
    .receive_state(receive_now),
    .bus_won(bus_won),
    .bus_reset(bus_reset),
    .pending(tr_pending),
    .req_type(tr_type),
    .req_speed(tr_speed)
  );

  lrsd_register_read_tracker u_rd (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .load(rd_load),
    .load_addr(shreg[3:0]),
    .delivered(read_delivered),
    .pending(rt_pending),
    .addr(rt_addr)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      bus_req_pending <= 1'b0;
      bus_req_type <= 3'h0;
      bus_req_speed <= 3'h0;
      bus_req_speed_invalid <= 1'b0;
      bus_req_arb_mode <= LRSD_ARB_NONE;
      bus_req_fair <= 1'b0;
      read_pending <= 1'b0;
      read_addr <= 4'h0;
      write_strobe <= 1'b0;
      write_addr <= 4'h0;
      write_data <= 8'h00;
      accel_enabled <= 1'b0;
      stream_error <= 1'b0;
    end else if (ce) begin
      bus_req_pending <= tr_pending;
      bus_req_type <= tr_type;
      bus_req_speed <= tr_speed;
      bus_req_speed_invalid <= tr_pending && !speed_ok(tr_speed);
      bus_req_arb_mode <= tr_pending ? arb_mode_now : LRSD_ARB_NONE;
      bus_req_fair <= tr_pending && (tr_type == `LRSD_TYPE_FAIR);
      read_pending <= rt_pending;
      read_addr <= rt_addr;
      write_strobe <= wr_hit;
      if (wr_hit) begin
        write_addr <= shreg[11:8];
        write_data <= shreg[7:0];
      end
      if (acc_hit) begin
        accel_enabled <= shreg[0];
      end else if ((bus_reset || (bus_load && typ == `LRSD_TYPE_ISO)) && accel_enable_bit) begin
        accel_enabled <= 1'b1;
      end
      stream_error <= bad_stop || rsvd_seen;
    end
  end

endmodule
`default_nettype wire

// ==== dv/lrsd_link_model.sv ====
// Purpose: link controller model driving the request line
// Assumes: stream given left aligned, start bit in bit 16
// Notes: line held low between streams
`timescale 1ns/100ps
`default_nettype none
module lrsd_link_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic go,
  input wire logic [16:0] bits,
  input wire logic [4:0] len,
  output logic link_request_line,
  output logic busy
);
  logic [16:0] sh;
  logic [4:0] n;
  assign link_request_line = busy & sh[16];
  always_ff @(posedge clk) begin
    if (srst) begin
      busy <= 1'b0;
    end else if (go && !busy) begin
      sh <= bits;
      n <= len;
      busy <= 1'b1;
    end else if (busy) begin
      sh <= sh << 1;
      n <= n - 5'h01;
      busy <= n != 5'h01;
    end
  end
endmodule
`default_nettype wire

// ==== dv/lrsd_checker.sv ====
// Purpose: port checks for the request stream decoder
// Assumes: ce held high
// Notes: bound from the bench top
`timescale 1ns/100ps
`default_nettype none
module lrsd_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic link_request_line,
  input wire logic [1:0] interface_control_bus,
  input wire logic read_delivered,
  input wire logic bus_req_pending,
  input wire logic [2:0] bus_req_type,
  input wire logic [2:0] bus_req_speed,
  input wire logic bus_req_speed_invalid,
  input wire logic [1:0] bus_req_arb_mode,
  input wire logic bus_req_fair,
  input wire logic read_pending,
  input wire logic [3:0] read_addr,
  input wire logic write_strobe,
  input wire logic stream_error
);
  logic [1:0] exp_arb;
  logic spd_ok;
  assign exp_arb = (bus_req_type == 3'h0) ? 2'h1 : (bus_req_type == 3'h1) ? 2'h2 : 2'h3;
  assign spd_ok = bus_req_speed inside {3'h0, 3'h2, 3'h4};
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  AST_RX_CLEAR: assert property (
    interface_control_bus == 2'h2 && bus_req_pending && bus_req_type[2:1] == 2'h1
    |-> ##[1:3] !bus_req_pending) else $error("receive left request");
  AST_SPEED_BAD: assert property (
    bus_req_speed_invalid == (bus_req_pending && !spd_ok)) else $error("speed flag");
  AST_ARB_MODE: assert property (
    bus_req_pending |-> bus_req_arb_mode == exp_arb) else $error("arb mode");
  AST_FAIR: assert property (
    bus_req_fair == (bus_req_pending && bus_req_type == 3'h3)) else $error("fair flag");
  AST_ONE_BUS: assert property (
    bus_req_pending ##1 bus_req_pending |-> $stable(bus_req_type)) else $error("type moved");
  AST_READ_HOLD: assert property (
    read_pending && !read_delivered && !$past(read_delivered) |=> read_pending)
    else $error("read dropped");
  AST_READ_ADDR: assert property (
    read_pending ##1 read_pending |-> $stable(read_addr)) else $error("read addr moved");
  AST_WR_STOP: assert property (
    write_strobe |-> !$past(link_request_line)) else $error("write without stop");
  AST_WR_PULSE: assert property (
    write_strobe |=> !write_strobe) else $error("strobe too long");
  cover property (write_strobe);
  cover property (bus_req_fair);
  cover property (stream_error);
endmodule
`default_nettype wire

// ==== dv/lrsd_link_request_stream_decoder_tb_top.sv ====
// Purpose: bench for the request stream decoder
// Assumes: outputs settle two edges after the last bit
// Notes: one task per scenario
`timescale 1ns/100ps
`default_nettype none
module lrsd_link_request_stream_decoder_tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic [1:0] interface_control_bus = 2'h0;
  logic bus_won = 1'b0, bus_reset = 1'b0, read_delivered = 1'b0, accel_enable_bit = 1'b1;
  logic go = 1'b0;
  logic [16:0] bits = 17'h0_0000;
  logic [4:0] len = 5'h00;
  logic link_request_line, busy, bus_req_pending, bus_req_speed_invalid, bus_req_fair;
  logic read_pending, write_strobe, accel_enabled, stream_error;
  logic [2:0] bus_req_type, bus_req_speed;
  logic [1:0] bus_req_arb_mode;
  logic [3:0] read_addr, write_addr;
  logic [7:0] write_data;
  int errors = 0, checks_done = 0, nstb = 0, nerr = 0;
  lrsd_link_request_stream_decoder lrsd_link_request_stream_decoder_i (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .link_request_line(link_request_line),
    .interface_control_bus(interface_control_bus),
    .bus_won(bus_won),
    .bus_reset(bus_reset),
    .read_delivered(read_delivered),
    .accel_enable_bit(accel_enable_bit),
    .bus_req_pending(bus_req_pending),
    .bus_req_type(bus_req_type),
    .bus_req_speed(bus_req_speed),
    .bus_req_speed_invalid(bus_req_speed_invalid),
    .bus_req_arb_mode(bus_req_arb_mode),
    .bus_req_fair(bus_req_fair),
    .read_pending(read_pending),
    .read_addr(read_addr),
    .write_strobe(write_strobe),
    .write_addr(write_addr),
    .write_data(write_data),
    .accel_enabled(accel_enabled),
    .stream_error(stream_error)
  );
  lrsd_link_model lrsd_link_model_i (
    .clk(clk),
    .srst(srst),
    .go(go),
    .bits(bits),
    .len(len),
    .link_request_line(link_request_line),
    .busy(busy)
  );
  always #20 clk = ~clk;
  always @(posedge clk) begin
    nstb += write_strobe;
    nerr += stream_error;
  end
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic send(input logic [16:0] b, input logic [4:0] n);
    int k;
    bits <= b;
    len <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    k = 0;
    @(posedge clk);
    while (busy && k < 30) begin
      @(posedge clk);
      k++;
    end
    cmp("busy", 8'h00, 8'(busy));
    repeat (3) @(posedge clk);
  endtask
  task automatic pulse(input logic [3:0] p);
    {interface_control_bus[1], bus_won, bus_reset, read_delivered} <= p;
    @(posedge clk);
    {interface_control_bus[1], bus_won, bus_reset, read_delivered} <= 4'h0;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_write();
    int s;
    s = nstb;
    send({1'b1, 3'h5, 4'ha, 8'h5c, 1'b0}, 5'h11);
    cmp("strobes", 8'(s + 1), 8'(nstb));
    cmp("waddr", 8'h0a, write_addr);
    cmp("wdata", 8'h5c, write_data);
    $display("test write done");
  endtask
  task automatic t_read();
    send({1'b1, 3'h4, 4'h3, 1'b0, 8'h00}, 5'h09);
    cmp("rdp", 1'b1, read_pending);
    send({1'b1, 3'h4, 4'h6, 1'b0, 8'h00}, 5'h09);
    pulse(4'h2);
    cmp("rdp_rst", 1'b1, read_pending);
    cmp("raddr", 8'h03, read_addr);
    pulse(4'h1);
    cmp("rdp_done", 1'b0, read_pending);
    $display("test read done");
  endtask
  task automatic t_bus();
    logic [2:0] sp [4] = '{3'h0, 3'h2, 3'h4, 3'h3};
    logic [1:0] am [4] = '{2'h1, 2'h2, 2'h3, 2'h3};
    for (int i = 0; i < 4; i++) begin
      send({1'b1, 3'(i), sp[i], 1'b0, 9'h000}, i == 1 ? 5'h07 : 5'h08);
      cmp("arb", am[i], bus_req_arb_mode);
      cmp("speed", sp[i], bus_req_speed);
      cmp("sinv", i == 3, bus_req_speed_invalid);
      cmp("fair", i == 3, bus_req_fair);
      send({1'b1, 3'h0, 3'h0, 1'b0, 9'h000}, 5'h08);
      cmp("type", 3'(i), bus_req_type);
      pulse(i == 3 ? 4'h2 : 4'h4);
      cmp("clear", 1'b0, bus_req_pending);
    end
    $display("test bus done");
  endtask
  task automatic t_rx();
    send({1'b1, 3'h3, 3'h0, 1'b0, 9'h000}, 5'h08);
    cmp("rx_fair_set", 1'b1, bus_req_pending);
    pulse(4'h8);
    cmp("rx_fair", 1'b0, bus_req_pending);
    interface_control_bus <= 2'h2;
    send({1'b1, 3'h2, 3'h0, 1'b0, 9'h000}, 5'h08);
    interface_control_bus <= 2'h0;
    cmp("rx_pri", 1'b0, bus_req_pending);
    send({1'b1, 3'h1, 3'h0, 1'b0, 9'h000}, 5'h08);
    pulse(4'h8);
    cmp("rx_iso", 1'b1, bus_req_pending);
    pulse(4'h4);
    cmp("rx_iso_won", 1'b0, bus_req_pending);
    $display("test receive done");
  endtask
  task automatic t_misc();
    int s;
    int w;
    s = nerr;
    w = nstb;
    send({1'b1, 3'h6, 1'b0, 1'b0, 11'h000}, 5'h06);
    cmp("acc_off", 1'b0, accel_enabled);
    accel_enable_bit <= 1'b0;
    pulse(4'h2);
    cmp("acc_keep", 1'b0, accel_enabled);
    send({1'b1, 3'h6, 1'b1, 1'b0, 11'h000}, 5'h06);
    cmp("acc_on", 1'b1, accel_enabled);
    accel_enable_bit <= 1'b1;
    send({1'b1, 3'h7, 13'h1fff}, 5'h0c);
    cmp("serr", 8'(s + 1), 8'(nerr));
    cmp("rsvd", 1'b0, bus_req_pending | read_pending);
    send({1'b1, 3'h5, 4'h1, 8'h00, 1'b1}, 5'h11);
    cmp("badstop", 8'(s + 2), 8'(nerr));
    cmp("badstop_wr", 8'(w), 8'(nstb));
    send({1'b1, 3'h4, 4'h9, 1'b0, 8'h00}, 5'h09);
    cmp("after", 8'h09, read_addr);
    $display("test misc done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_write();
    t_read();
    t_bus();
    t_rx();
    t_misc();
    report_and_stop();
  end
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    report_and_stop();
  end
endmodule
bind lrsd_link_request_stream_decoder lrsd_checker lrsd_checker_i (
  .clk(clk),
  .srst(srst),
  .link_request_line(link_request_line),
  .interface_control_bus(interface_control_bus),
  .read_delivered(read_delivered),
  .bus_req_pending(bus_req_pending),
  .bus_req_type(bus_req_type),
  .bus_req_speed(bus_req_speed),
  .bus_req_speed_invalid(bus_req_speed_invalid),
  .bus_req_arb_mode(bus_req_arb_mode),
  .bus_req_fair(bus_req_fair),
  .read_pending(read_pending),
  .read_addr(read_addr),
  .write_strobe(write_strobe),
  .stream_error(stream_error)
);
`default_nettype wire
